// ---- hdl/epr_pkg.sv ----
package epr_pkg;

  // ***************************************************************
  // parameter addresses on the fieldbus access port
  // ***************************************************************
  localparam logic [15:0] ADDR_RANGE_SHIFT   = 16'h0542;
  localparam logic [15:0] ADDR_RETENTION     = 16'h0546;
  localparam logic [15:0] ADDR_CAPTURE_CTRL  = 16'h19A0;
  localparam logic [15:0] ADDR_CAPTURE_STAT  = 16'h19A2;

  // ***************************************************************
  // field layout and values
  // ***************************************************************
  localparam int unsigned TURN_W  = 12;   // multiturn span of 4096 revs
  localparam int unsigned ANGLE_W = 16;   // singleturn resolution
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned CAP_ONE_BIT = 0;
  localparam int unsigned CAP_TWO_BIT = 1;
  localparam int unsigned ENABLE_BIT  = 0;

  // half of the multiturn span, used when shifting is on
  localparam logic [TURN_W-1:0]  TURN_HALF    = 12'h800;
  localparam logic [TURN_W-1:0]  TURN_ONE     = 12'h001;
  localparam logic [TURN_W-1:0]  TURN_ZERO    = 12'h000;
  // a quarter revolution in angle counts
  localparam logic [ANGLE_W-1:0] ANGLE_QUARTER = 16'h4000;
  localparam logic [1:0] QUAD_LOW  = 2'b00;
  localparam logic [1:0] QUAD_HIGH = 2'b11;
  localparam logic [DATA_W-1:0]  DATA_ZERO    = 16'h0000;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef struct packed {
    logic [TURN_W-1:0]  turns;
    logic [ANGLE_W-1:0] angle;
  } epr_pos_s;

  localparam epr_pos_s POS_ZERO = '{turns: 12'h000, angle: 16'h0000};

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [15:0]       addr;
    logic [DATA_W-1:0] data;
  } epr_req_s;

  // record kept in non-volatile storage across a power cycle
  typedef struct packed {
    logic     rangeShift;
    logic     retention;
    logic     savedValid;
    epr_pos_s pos;
  } epr_nv_s;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_RUN  = 3'b010,
    ST_HALT = 3'b100
  } epr_state_e;

endpackage

// ---- hdl/epr_capture_unit.sv ----
`timescale 1ns/1ps
`default_nettype none

module epr_capture_unit (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              armSet,
  input  wire logic              armClr,
  input  wire logic              trigIn,
  input  wire epr_pkg::epr_pos_s posIn,
  output logic                   armed,
  output logic                   done,
  output epr_pkg::epr_pos_s      capPos
);
  import epr_pkg::*;

  logic     trigPrev_q;
  logic     armed_q;
  logic     done_q;
  epr_pos_s capPos_q;
  logic     fire;

  // active event is a rising edge of the capture input
  assign fire = armed_q & trigIn & ~trigPrev_q;

  // edge detector history
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= trigIn;
    end
  end

  // arm state: cancel acts at once, a capture disarms the unit
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
    end else if (armClr) begin
      armed_q <= 1'b0;
    end else if (armSet) begin
      armed_q <= 1'b1;
    end else if (fire) begin
      armed_q <= 1'b0;
    end
  end

  // done flag: a capture wins over the re-arm that clears it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else if (fire) begin
      done_q <= 1'b1;
    end else if (armSet) begin
      done_q <= 1'b0;
    end
  end

  // latched position, held until the next capture
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      capPos_q <= POS_ZERO;
    end else if (fire) begin
      capPos_q <= posIn;
    end
  end

  assign armed  = armed_q;
  assign done   = done_q;
  assign capPos = capPos_q;

endmodule // epr_capture_unit

`default_nettype wire

// ---- hdl/epr_turn_track.sv ----
`timescale 1ns/1ps
`default_nettype none

module epr_turn_track (
  input  wire logic                            sys_clk,
  input  wire logic                            sys_rst,
  input  wire logic                            load,
  input  wire logic [epr_pkg::TURN_W-1:0]      loadTurns,
  input  wire logic [epr_pkg::ANGLE_W-1:0]     angle,
  output logic [epr_pkg::TURN_W-1:0]           turns
);
  import epr_pkg::*;

  logic [1:0]        quadPrev_q;
  logic [TURN_W-1:0] turns_q;
  logic [1:0]        quadNow;

  // wrap is seen from the top two angle bits; motion per sample must
  // stay under a quarter turn or a wrap is miscounted
  assign quadNow = angle[ANGLE_W-1 -: 2];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      quadPrev_q <= QUAD_LOW;
    end else begin
      quadPrev_q <= quadNow;
    end
  end

  // turn counter for singleturn encoders
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      turns_q <= TURN_ZERO;
    end else if (load) begin
      turns_q <= loadTurns;
    end else if (quadPrev_q == QUAD_HIGH && quadNow == QUAD_LOW) begin
      turns_q <= turns_q + TURN_ONE;
    end else if (quadPrev_q == QUAD_LOW && quadNow == QUAD_HIGH) begin
      turns_q <= turns_q - TURN_ONE;
    end
  end

  assign turns = turns_q;

endmodule // epr_turn_track

`default_nettype wire

// ---- hdl/epr_position_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module epr_position_top (
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  // fieldbus parameter access
  input  wire epr_pkg::epr_req_s           paramReq,
  output logic                             paramAck,
  output logic                             paramErr,
  output logic [epr_pkg::DATA_W-1:0]       paramRdData,
  // encoder
  input  wire logic                        encMultiturn,
  input  wire logic [epr_pkg::TURN_W-1:0]  encTurns,
  input  wire logic [epr_pkg::ANGLE_W-1:0] encAngle,
  // capture inputs
  input  wire logic                        captureInputOne,
  input  wire logic                        captureInputTwo,
  // non-volatile record across power cycles
  input  wire epr_pkg::epr_nv_s            nvRestore,
  input  wire logic                        shutdownReq,
  output logic                             nvSaveStrobe,
  output epr_pkg::epr_nv_s                 nvSave,
  // position results
  output epr_pkg::epr_pos_s                posOut,
  output logic                             posSigned,
  output logic                             restoreFail,
  output epr_pkg::epr_pos_s                capPosOne,
  output epr_pkg::epr_pos_s                capPosTwo,
  output logic                             ready
);
  import epr_pkg::*;

  // ***************************************************************
  // declarations
  // ***************************************************************
  epr_state_e        state_q;
  epr_state_e        state_d;
  logic              rangeShiftReg_q;
  logic              rangeShiftAct_q;
  logic              retention_q;
  logic              restoreFail_q;
  epr_pos_s          posOut_q;
  logic              ack_q;
  logic              err_q;
  logic [DATA_W-1:0] rdData_q;
  logic              saveStrobe_q;
  epr_nv_s           save_q;

  logic              booting;
  logic              wrHit;
  logic              ctrlWr;
  logic              armSetOne;
  logic              armSetTwo;
  logic              armClrOne;
  logic              armClrTwo;
  logic              armedOne;
  logic              armedTwo;
  logic              doneOne;
  logic              doneTwo;
  logic [TURN_W-1:0] trackTurns;
  logic [TURN_W-1:0] turnsNow;
  logic [TURN_W-1:0] restoreTurns;
  logic [TURN_W-1:0] reportTurns;
  logic [ANGLE_W-1:0] angleDiff;
  logic [ANGLE_W-1:0] angleDist;
  logic              restoreOk;
  logic              restoreWanted;
  logic [1:0]        quadSaved;
  logic [1:0]        quadNow;
  logic              addrKnown;
  epr_pos_s          mechPos;

  assign booting = (state_q == ST_BOOT);

  // ***************************************************************
  // power sequence: boot, run, halted after shutdown
  // ***************************************************************
  // boot lasts one cycle so the persistent record is read once only
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_BOOT: state_d = ST_RUN;
      ST_RUN:  state_d = shutdownReq ? ST_HALT : ST_RUN;
      ST_HALT: state_d = ST_HALT;
      default: state_d = ST_BOOT;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_BOOT;
    end else begin
      state_q <= state_d;
    end
  end

  // ***************************************************************
  // restore check at power-up
  // ***************************************************************
  // distance between saved and present angle, folded to one side
  assign angleDiff = encAngle - nvRestore.pos.angle;
  assign angleDist = angleDiff[ANGLE_W-1] ? (~angleDiff + 16'h0001)
                                          : angleDiff;
  assign restoreWanted = nvRestore.retention & nvRestore.savedValid;
  assign restoreOk = restoreWanted &
                     (encMultiturn | (angleDist <= ANGLE_QUARTER));

  // saved turn count, corrected when the shaft crossed the zero angle
  assign quadSaved = nvRestore.pos.angle[ANGLE_W-1 -: 2];
  assign quadNow   = encAngle[ANGLE_W-1 -: 2];
  always_comb begin
    restoreTurns = nvRestore.pos.turns;
    if (quadSaved == QUAD_HIGH && quadNow == QUAD_LOW) begin
      restoreTurns = nvRestore.pos.turns + TURN_ONE;
    end else if (quadSaved == QUAD_LOW && quadNow == QUAD_HIGH) begin
      restoreTurns = nvRestore.pos.turns - TURN_ONE;
    end
  end

  // a singleturn encoder gets its turn count from the tracker
  epr_turn_track u_track (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .load      (booting),
    .loadTurns (restoreOk ? restoreTurns : TURN_ZERO),
    .angle     (encAngle),
    .turns     (trackTurns)
  );

  assign turnsNow = encMultiturn ? encTurns : trackTurns;
  assign mechPos  = '{turns: turnsNow, angle: encAngle};

  // failed restore is shown until the next power-up
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      restoreFail_q <= 1'b0;
    end else if (booting) begin
      restoreFail_q <= restoreWanted & ~restoreOk;
    end
  end

  // ***************************************************************
  // range shifting
  // ***************************************************************
  // active setting is fixed at boot; writes only touch the stored copy
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rangeShiftAct_q <= 1'b0;
    end else if (booting) begin
      rangeShiftAct_q <= nvRestore.rangeShift;
    end
  end

  // half-span offset; the 12-bit field then reads as two's complement
  assign reportTurns = rangeShiftAct_q ? (turnsNow - TURN_HALF)
                                       : turnsNow;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      posOut_q <= POS_ZERO;
    end else begin
      posOut_q <= '{turns: reportTurns, angle: encAngle};
    end
  end

  // ***************************************************************
  // parameter registers
  // ***************************************************************
  assign wrHit  = paramReq.wr & ~booting;
  assign ctrlWr = wrHit & (paramReq.addr == ADDR_CAPTURE_CTRL);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rangeShiftReg_q <= 1'b0;
    end else if (booting) begin
      rangeShiftReg_q <= nvRestore.rangeShift;
    end else if (wrHit && paramReq.addr == ADDR_RANGE_SHIFT) begin
      rangeShiftReg_q <= paramReq.data[ENABLE_BIT];
    end
  end

  // retention setting acts at once on the next shutdown
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      retention_q <= 1'b0;
    end else if (booting) begin
      retention_q <= nvRestore.retention;
    end else if (wrHit && paramReq.addr == ADDR_RETENTION) begin
      retention_q <= paramReq.data[ENABLE_BIT];
    end
  end

  // ***************************************************************
  // capture arming
  // ***************************************************************
  // only bits 0 and 1 are decoded; higher bits have no effect
  assign armSetOne = ctrlWr & paramReq.data[CAP_ONE_BIT];
  assign armClrOne = ctrlWr & ~paramReq.data[CAP_ONE_BIT];
  assign armSetTwo = ctrlWr & paramReq.data[CAP_TWO_BIT];
  assign armClrTwo = ctrlWr & ~paramReq.data[CAP_TWO_BIT];

  epr_capture_unit u_cap_one (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .armSet  (armSetOne),
    .armClr  (armClrOne),
    .trigIn  (captureInputOne),
    .posIn   (posOut_q),
    .armed   (armedOne),
    .done    (doneOne),
    .capPos  (capPosOne)
  );

  epr_capture_unit u_cap_two (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .armSet  (armSetTwo),
    .armClr  (armClrTwo),
    .trigIn  (captureInputTwo),
    .posIn   (posOut_q),
    .armed   (armedTwo),
    .done    (doneTwo),
    .capPos  (capPosTwo)
  );

  // ***************************************************************
  // read path and acknowledge
  // ***************************************************************
  assign addrKnown = (paramReq.addr == ADDR_RANGE_SHIFT) |
                     (paramReq.addr == ADDR_RETENTION) |
                     (paramReq.addr == ADDR_CAPTURE_CTRL) |
                     (paramReq.addr == ADDR_CAPTURE_STAT);

  // one-cycle answer; status is read-only so writes there are errors
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q    <= 1'b0;
      err_q    <= 1'b0;
      rdData_q <= DATA_ZERO;
    end else begin
      ack_q    <= (paramReq.wr | paramReq.rd) & ~booting;
      err_q    <= (paramReq.wr | paramReq.rd) & ~booting &
                  (~addrKnown |
                   (paramReq.wr && paramReq.addr == ADDR_CAPTURE_STAT));
      rdData_q <= DATA_ZERO;
      if (paramReq.rd && !booting) begin
        unique case (paramReq.addr)
          ADDR_RANGE_SHIFT:  rdData_q[ENABLE_BIT] <= rangeShiftReg_q;
          ADDR_RETENTION:    rdData_q[ENABLE_BIT] <= retention_q;
          ADDR_CAPTURE_CTRL: begin
            rdData_q[CAP_ONE_BIT] <= armedOne;
            rdData_q[CAP_TWO_BIT] <= armedTwo;
          end
          ADDR_CAPTURE_STAT: begin
            rdData_q[CAP_ONE_BIT] <= doneOne;
            rdData_q[CAP_TWO_BIT] <= doneTwo;
          end
          default: rdData_q <= DATA_ZERO;
        endcase
      end
    end
  end

  // ***************************************************************
  // shutdown save
  // ***************************************************************
  // caller must only shut down at standstill, so one sample suffices
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      saveStrobe_q <= 1'b0;
      save_q       <= '0;
    end else begin
      saveStrobe_q <= 1'b0;
      if (state_q == ST_RUN && shutdownReq) begin
        saveStrobe_q      <= 1'b1;
        save_q.rangeShift <= rangeShiftReg_q;
        save_q.retention  <= retention_q;
        save_q.savedValid <= retention_q;
        save_q.pos        <= retention_q ? mechPos : POS_ZERO;
      end
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign paramAck     = ack_q;
  assign paramErr     = err_q;
  assign paramRdData  = rdData_q;
  assign nvSaveStrobe = saveStrobe_q;
  assign nvSave       = save_q;
  assign posOut       = posOut_q;
  assign posSigned    = rangeShiftAct_q;
  assign restoreFail  = restoreFail_q;
  assign ready        = (state_q == ST_RUN);

endmodule // epr_position_top

`default_nettype wire

// ---- bench/epr_position_top_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

module epr_position_properties (
  input wire logic                        sys_clk,
  input wire logic                        sys_rst,
  input wire epr_pkg::epr_req_s           paramReq,
  input wire logic                        paramAck,
  input wire logic                        paramErr,
  input wire logic [epr_pkg::DATA_W-1:0]  paramRdData,
  input wire logic                        captureInputOne,
  input wire logic                        captureInputTwo,
  input wire logic                        shutdownReq,
  input wire logic                        nvSaveStrobe,
  input wire epr_pkg::epr_nv_s            nvSave,
  input wire epr_pkg::epr_pos_s           posOut,
  input wire logic                        posSigned,
  input wire epr_pkg::epr_pos_s           capPosOne,
  input wire epr_pkg::epr_pos_s           capPosTwo,
  input wire logic                        ready
);
  import epr_pkg::*;

  // ***************************************************************
  // decoded request conditions
  // ***************************************************************
  logic taken;
  logic unmapped;
  assign taken    = ready && (paramReq.wr || paramReq.rd);
  assign unmapped = paramReq.addr != ADDR_RANGE_SHIFT
                 && paramReq.addr != ADDR_RETENTION
                 && paramReq.addr != ADDR_CAPTURE_CTRL
                 && paramReq.addr != ADDR_CAPTURE_STAT;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_ack_after_req: assert property (taken |=> paramAck)
    else $error("request not acknowledged");
  a_err_unmapped: assert property (ready && paramReq.rd && unmapped
    |=> paramAck && paramErr)
    else $error("unmapped read not flagged");
  a_err_with_ack: assert property (paramErr |-> paramAck)
    else $error("error without acknowledge");
  a_status_layout: assert property (
    ready && paramReq.rd && paramReq.addr == ADDR_CAPTURE_STAT
    |=> paramRdData[15:2] == 14'h0000)
    else $error("status upper bits set");
  a_ctrl_reserved: assert property (
    ready && paramReq.rd && paramReq.addr == ADDR_CAPTURE_CTRL
    |=> paramRdData[15:2] == 14'h0000)
    else $error("reserved control bits stored");
  a_cap_one_latch: assert property (!$stable(capPosOne) |->
    $past(captureInputOne) && !$past(captureInputOne, 2)
    && capPosOne == $past(posOut))
    else $error("capture one latched without edge");
  a_cap_two_latch: assert property (!$stable(capPosTwo) |->
    $past(captureInputTwo) && !$past(captureInputTwo, 2)
    && capPosTwo == $past(posOut))
    else $error("capture two latched without edge");
  a_shift_frozen: assert property (
    ready && $past(ready) |-> $stable(posSigned))
    else $error("range setting changed while running");
  a_save_on_stop: assert property (
    ready && shutdownReq |=> nvSaveStrobe && !ready)
    else $error("shutdown did not save");
  a_discard_pos: assert property (
    nvSaveStrobe && !nvSave.retention
    |-> !nvSave.savedValid && nvSave.pos == POS_ZERO)
    else $error("position kept with retention off");

endmodule // epr_position_properties

bind epr_position_top epr_position_properties u_epr_position_properties (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .paramReq(paramReq),
  .paramAck(paramAck),
  .paramErr(paramErr),
  .paramRdData(paramRdData),
  .captureInputOne(captureInputOne),
  .captureInputTwo(captureInputTwo),
  .shutdownReq(shutdownReq),
  .nvSaveStrobe(nvSaveStrobe),
  .nvSave(nvSave),
  .posOut(posOut),
  .posSigned(posSigned),
  .capPosOne(capPosOne),
  .capPosTwo(capPosTwo),
  .ready(ready)
);

`default_nettype wire

// ---- bench/epr_encoder_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module epr_encoder_model (
  input  wire logic                        sys_clk,
  output logic                             encMultiturn,
  output logic [epr_pkg::TURN_W-1:0]       encTurns,
  output logic [epr_pkg::ANGLE_W-1:0]      encAngle,
  output logic                             captureInputOne,
  output logic                             captureInputTwo
);
  import epr_pkg::*;

  // shaft at rest, both capture lines low
  initial begin
    encMultiturn    = 1'b1;
    encTurns        = TURN_ZERO;
    encAngle        = 16'h0000;
    captureInputOne = 1'b0;
    captureInputTwo = 1'b0;
  end

  // the shaft only moves when told; moves made while off stay in the
  // allowed window unless a scenario wants a refused restore
  task automatic move(input logic mt, input logic [TURN_W-1:0] t,
                      input logic [ANGLE_W-1:0] a);
    @(posedge sys_clk);
    encMultiturn <= mt;
    encTurns     <= t;
    encAngle     <= a;
    repeat (4) @(posedge sys_clk);
  endtask

  // one rising edge, held two cycles so it cannot be missed
  task automatic strobe(input logic two);
    @(posedge sys_clk);
    if (two) captureInputTwo <= 1'b1;
    else captureInputOne <= 1'b1;
    repeat (2) @(posedge sys_clk);
    captureInputOne <= 1'b0;
    captureInputTwo <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

endmodule // epr_encoder_model

`default_nettype wire

// ---- bench/epr_position_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module epr_position_top_tb;
  import epr_pkg::*;

  logic                sys_clk = 1'b0;
  logic                sys_rst = 1'b1;
  epr_req_s            paramReq = '0;
  logic                shutdownReq = 1'b0;
  epr_nv_s             nvRestore = '0;
  logic                paramAck, paramErr, nvSaveStrobe, posSigned;
  logic                restoreFail, ready, encMultiturn, capOne, capTwo;
  logic [DATA_W-1:0]   paramRdData, rdData;
  logic [TURN_W-1:0]   encTurns;
  logic [ANGLE_W-1:0]  encAngle;
  epr_nv_s             nvSave, saved;
  epr_pos_s            posOut, capPosOne, capPosTwo;
  logic                rdErr;
  int                  n_mismatch = 0;
  int                  samples_checked = 0;

  always #2.5 sys_clk = ~sys_clk;

  // non-volatile store: survives the resets that model power cycles
  always @(posedge sys_clk) if (nvSaveStrobe) nvRestore <= nvSave;

  epr_encoder_model u_epr_encoder_model (.sys_clk(sys_clk),
    .encMultiturn(encMultiturn), .encTurns(encTurns), .encAngle(encAngle),
    .captureInputOne(capOne), .captureInputTwo(capTwo));

  epr_position_top u_epr_position_top (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .paramReq(paramReq), .paramAck(paramAck),
    .paramErr(paramErr), .paramRdData(paramRdData),
    .encMultiturn(encMultiturn), .encTurns(encTurns), .encAngle(encAngle),
    .captureInputOne(capOne), .captureInputTwo(capTwo),
    .nvRestore(nvRestore), .shutdownReq(shutdownReq),
    .nvSaveStrobe(nvSaveStrobe), .nvSave(nvSave), .posOut(posOut),
    .posSigned(posSigned), .restoreFail(restoreFail),
    .capPosOne(capPosOne), .capPosTwo(capPosTwo), .ready(ready));

  // ***************************************************************
  // compare, access and power tasks
  // ***************************************************************
  task automatic chk16(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chkPos(input string what, input epr_pos_s exp,
                        input epr_pos_s got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // request held until the taking edge; answer read one cycle on
  task automatic access(input logic isWr, input logic [15:0] addr,
                        input logic [15:0] data);
    @(posedge sys_clk);
    paramReq <= '{wr: isWr, rd: !isWr, addr: addr, data: data};
    @(posedge sys_clk);
    paramReq <= '0;
    #1;
    rdErr = paramErr;
    rdData = paramRdData;
    chk16("acknowledge", 16'h0001, {15'h0000, paramAck});
  endtask

  task automatic rdchk(input logic [15:0] addr, input logic [15:0] exp,
                       input logic err);
    access(1'b0, addr, 16'h0000);
    chk16("read data", exp, rdData);
    chk16("error flag", {15'h0000, err}, {15'h0000, rdErr});
  endtask

  task automatic power_cycle();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk16("ready", 16'h0001, {15'h0000, ready});
  endtask

  task automatic shutdown();
    @(posedge sys_clk);
    shutdownReq <= 1'b1;
    @(posedge sys_clk);
    shutdownReq <= 1'b0;
    #1;
    chk16("save strobe", 16'h0001, {15'h0000, nvSaveStrobe});
    saved = nvSave;
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // run takes about two hundred cycles; fifty times that means a hang
  initial begin
    #50000;
    n_mismatch++;
    end_of_test();
  end

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    power_cycle();
    rdchk(ADDR_RANGE_SHIFT, 16'h0000, 1'b0);
    access(1'b1, ADDR_CAPTURE_CTRL, 16'hFFFC);
    rdchk(ADDR_CAPTURE_CTRL, 16'h0000, 1'b0);
    rdchk(16'h0544, 16'h0000, 1'b1);
    access(1'b1, ADDR_CAPTURE_STAT, 16'h0003);
    chk16("status write error", 16'h0001, {15'h0000, rdErr});
    $display("test registers done");
    u_epr_encoder_model.move(1'b1, 12'h005, 16'h1234);
    access(1'b1, ADDR_CAPTURE_CTRL, 16'h0001);
    u_epr_encoder_model.strobe(1'b0);
    rdchk(ADDR_CAPTURE_STAT, 16'h0001, 1'b0);
    chkPos("capture one", '{12'h005, 16'h1234}, capPosOne);
    u_epr_encoder_model.move(1'b1, 12'h009, 16'h1234);
    u_epr_encoder_model.strobe(1'b0);
    chkPos("capture one again", '{12'h005, 16'h1234}, capPosOne);
    access(1'b1, ADDR_CAPTURE_CTRL, 16'h0002);
    access(1'b1, ADDR_CAPTURE_CTRL, 16'h0000);
    u_epr_encoder_model.strobe(1'b1);
    rdchk(ADDR_CAPTURE_STAT, 16'h0001, 1'b0);
    access(1'b1, ADDR_CAPTURE_CTRL, 16'h0002);
    u_epr_encoder_model.strobe(1'b1);
    rdchk(ADDR_CAPTURE_STAT, 16'h0003, 1'b0);
    chkPos("capture two", '{12'h009, 16'h1234}, capPosTwo);
    access(1'b1, ADDR_CAPTURE_CTRL, 16'h0001);
    access(1'b1, ADDR_CAPTURE_CTRL, 16'h0000);
    u_epr_encoder_model.strobe(1'b0);
    rdchk(ADDR_CAPTURE_STAT, 16'h0002, 1'b0);
    $display("test capture done");
    u_epr_encoder_model.move(1'b1, 12'hFFF, 16'h0000);
    chkPos("unshifted top", '{12'hFFF, 16'h0000}, posOut);
    access(1'b1, ADDR_RANGE_SHIFT, 16'h0001);
    rdchk(ADDR_RANGE_SHIFT, 16'h0001, 1'b0);
    chk16("signed flag", 16'h0000, {15'h0000, posSigned});
    chkPos("before restart", '{12'hFFF, 16'h0000}, posOut);
    shutdown();
    chk16("saved shift", 16'h0001, {15'h0000, saved.rangeShift});
    power_cycle();
    chk16("signed flag", 16'h0001, {15'h0000, posSigned});
    chkPos("shifted top", '{12'h7FF, 16'h0000}, posOut);
    u_epr_encoder_model.move(1'b1, 12'h000, 16'h0000);
    chkPos("shifted bottom", '{12'h800, 16'h0000}, posOut);
    $display("test range done");
    access(1'b1, ADDR_RETENTION, 16'h0001);
    // a backward wrap leaves a nonzero turn count, so restore != discard
    u_epr_encoder_model.move(1'b0, 12'h000, 16'hC000);
    shutdown();
    chk16("saved flags", 16'h0003,
          {14'h0000, saved.retention, saved.savedValid});
    u_epr_encoder_model.move(1'b0, 12'h000, 16'hF000);
    power_cycle();
    chk16("restore refused", 16'h0000, {15'h0000, restoreFail});
    chkPos("restored position", '{12'h7FF, 16'hF000}, posOut);
    shutdown();
    u_epr_encoder_model.move(1'b0, 12'h000, 16'h9001);
    power_cycle();
    chk16("restore refused", 16'h0001, {15'h0000, restoreFail});
    access(1'b1, ADDR_RETENTION, 16'h0000);
    shutdown();
    chk16("saved valid", 16'h0000, {15'h0000, saved.savedValid});
    chkPos("saved position", POS_ZERO, saved.pos);
    $display("test retention done");
    end_of_test();
  end

endmodule // epr_position_top_tb

`default_nettype wire
